// ---- verilog/jtag_dbg_regs.vh ----
`ifndef JTAG_DBG_REGS_VH
`define JTAG_DBG_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_IDCODE        8'h08

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define CTRL_DBG_EN_BIT   0
`define CTRL_TRACE_LO     1
`define CTRL_TRACE_HI     2
`define CTRL_TO_JTAG_BIT  3
`define CTRL_RESET        32'h0000_0000

// ----------------------------------------------------------------------------
// Trace output selections
// ----------------------------------------------------------------------------
`define TRACE_OFF         2'h0
`define TRACE_SINGLE      2'h1
`define TRACE_PARALLEL    2'h2

// ----------------------------------------------------------------------------
// Debug port selection setting encodings
// ----------------------------------------------------------------------------
`define DPS_JTAG4         2'h0
`define DPS_JTAG5         2'h1
`define DPS_SWD           2'h2
`define DPS_DISABLED      2'h3

// ----------------------------------------------------------------------------
// Test access port instructions
// ----------------------------------------------------------------------------
`define INS_EXTEST        4'h0
`define INS_IDCODE        4'h1
`define INS_SAMPLE        4'h2
`define INS_DEVRESET      4'h8
`define INS_BYPASS        4'hF
`define IR_CAPTURE        4'h1

// ----------------------------------------------------------------------------
// Identity and key values (arbitrary)
// ----------------------------------------------------------------------------
`define DEV_IDCODE        32'h0ABC_0001
`define SWD_KEY           16'hE79E

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_PS     8000
`define KEY_WINDOW_US     8

`endif

// ---- verilog/pin_sync2.v ----
`timescale 1ns/1ps
`default_nettype none

module pin_sync2 #(
  parameter W = 6
) (
  input  wire         clk_sys,
  input  wire         rst_n,
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] pin_sync_q
);

  reg [W-1:0] meta_q;

  // The first stage feeds only the second stage
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q     <= {W{1'b0}};
      pin_sync_q <= {W{1'b0}};
    end else begin
      meta_q     <= pin_in;
      pin_sync_q <= meta_q;
    end
  end

endmodule // pin_sync2

`default_nettype wire

// ---- verilog/jtag_debug_port_access.v ----
// Function
// - Test port pins active by default; when disabled, pins become general I/O.
// - Four mandatory pins plus optional active-low test reset pin.
// - Both ports give debug access; only test port gives boundary scan.
// - Debug and trace units start disabled; only firmware enables them.
// - Host reset via test register honoured unless ports-disabled setting.
// - Mode-select pin input-only in test mode, bidirectional for serial-wire.
// - Security lock permanently disables all programming, debug, test ports.
// - Trace via single-pin output or multi-pin parallel port.
// - Serial-wire enabled on one pin pair after key within 8 us.
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "jtag_dbg_regs.vh"

module jtag_debug_port_access (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire        tck_in,
  input  wire        tms_in,
  input  wire        tdi_in,
  input  wire        trst_n_in,
  input  wire        usb_dp_in,
  input  wire        usb_dm_in,
  output reg         tdo_out,
  output reg         tdo_oe,
  output reg         tms_out,
  output reg         tms_oe,
  output reg         usb_dm_out,
  output reg         usb_dm_oe,
  input  wire        swd_drive,
  input  wire        swd_dout,
  input  wire [1:0]  debug_port_select_setting,
  input  wire        security_lock,
  input  wire [7:0]  bscan_in,
  output reg  [7:0]  bscan_out,
  output reg         bscan_oe,
  output reg         device_reset_req,
  output reg         jtag_pins_gpio,
  output reg         swd_on_jtag_pins,
  output reg         swd_on_usb_pins,
  output reg         debug_enable,
  output reg         single_pin_trace_output_en,
  output reg         parallel_trace_port_en
);

  // --------------------------------------------------------------------------
  // Constants
  // --------------------------------------------------------------------------
  localparam KEY_WIN_CYC = (`KEY_WINDOW_US * 1000000) / `CLK_PERIOD_PS;
  localparam [9:0] KEY_WIN = KEY_WIN_CYC[9:0];

  localparam [3:0] S_TLR   = 4'h0;
  localparam [3:0] S_RTI   = 4'h1;
  localparam [3:0] S_SELDR = 4'h2;
  localparam [3:0] S_CAPDR = 4'h3;
  localparam [3:0] S_SHDR  = 4'h4;
  localparam [3:0] S_EX1DR = 4'h5;
  localparam [3:0] S_PADR  = 4'h6;
  localparam [3:0] S_EX2DR = 4'h7;
  localparam [3:0] S_UPDR  = 4'h8;
  localparam [3:0] S_SELIR = 4'h9;
  localparam [3:0] S_CAPIR = 4'hA;
  localparam [3:0] S_SHIR  = 4'hB;
  localparam [3:0] S_EX1IR = 4'hC;
  localparam [3:0] S_PAIR  = 4'hD;
  localparam [3:0] S_EX2IR = 4'hE;
  localparam [3:0] S_UPIR  = 4'hF;

  // --------------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // --------------------------------------------------------------------------
  wire [5:0] pins_s;
  reg  [1:0] clk_prev_q;
  wire       tck_s = pins_s[0];
  wire       tms_s = pins_s[1];
  wire       tdi_s = pins_s[2];
  wire       trst_n_s = pins_s[3];
  wire       tck_rise = tck_s & ~clk_prev_q[0];
  wire       tck_fall = ~tck_s & clk_prev_q[0];
  wire       usb_rise = pins_s[4] & ~clk_prev_q[1];

  pin_sync2 #(.W(6)) u_sync (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .pin_in     ({usb_dm_in, usb_dp_in, trst_n_in, tdi_in, tms_in, tck_in}),
    .pin_sync_q (pins_s)
  );

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev_q <= 2'b00;
    end else begin
      clk_prev_q <= {pins_s[4], tck_s};
    end
  end

  // --------------------------------------------------------------------------
  // Strap capture after reset release
  // --------------------------------------------------------------------------
  reg       strap_done_q;
  reg [1:0] dps_q;
  reg       locked_q;
  reg       jtag_sel_q;
  reg       ctrl_to_jtag;

  // Until straps are caught everything behaves as disabled
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_q <= 1'b0;
      dps_q        <= `DPS_DISABLED;
      locked_q     <= 1'b1;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      dps_q        <= debug_port_select_setting;
      locked_q     <= security_lock;
    end
  end

  wire dps_jtag = (dps_q == `DPS_JTAG4) || (dps_q == `DPS_JTAG5);
  wire port_ok  = strap_done_q & ~locked_q;

  // --------------------------------------------------------------------------
  // Serial-wire key detection on both pin pairs
  // --------------------------------------------------------------------------
  reg  [9:0]  win_cnt_q;
  reg  [15:0] key_sr_q [0:1];
  reg  [1:0]  swd_q;
  wire [1:0]  pair_rise = {usb_rise, tck_rise};
  wire [1:0]  pair_dat  = {pins_s[5], tms_s};
  wire        win_open  = port_ok && (win_cnt_q < KEY_WIN);

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      win_cnt_q <= 10'h000;
    end else if (strap_done_q && win_open) begin
      win_cnt_q <= win_cnt_q + 10'h001;
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < 2; gp = gp + 1) begin : g_key
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          key_sr_q[gp] <= 16'h0000;
        end else if (ctrl_to_jtag) begin
          // A stale key must not re-acquire serial-wire after a switch back
          key_sr_q[gp] <= 16'h0000;
        end else if (pair_rise[gp]) begin
          key_sr_q[gp] <= {key_sr_q[gp][14:0], pair_dat[gp]};
        end
      end
    end
  endgenerate

  // First pair to see the key owns serial-wire; the other is locked out
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      swd_q <= 2'b00;
    end else if (!port_ok) begin
      swd_q <= 2'b00;
    end else if (ctrl_to_jtag) begin
      swd_q <= 2'b00;
    end else if (win_open && (swd_q == 2'b00)) begin
      if (key_sr_q[0] == `SWD_KEY) begin
        swd_q <= 2'b01;
      end else if (key_sr_q[1] == `SWD_KEY) begin
        swd_q <= 2'b10;
      end
    end
  end

  // Default selection brings the test port up; key or register may change it
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      jtag_sel_q <= 1'b0;
    end else if (!port_ok) begin
      jtag_sel_q <= 1'b0;
    end else if (ctrl_to_jtag) begin
      jtag_sel_q <= 1'b1;
    end else if (swd_q[0]) begin
      jtag_sel_q <= 1'b0;
    end else if (!strap_done_q || win_cnt_q == 10'h000) begin
      jtag_sel_q <= dps_jtag;
    end
  end

  wire jtag_on = jtag_sel_q & port_ok & ~swd_q[0];

  // --------------------------------------------------------------------------
  // Test access port controller
  // --------------------------------------------------------------------------
  reg  [3:0]  tap_q;
  reg  [3:0]  tap_d;
  reg  [3:0]  ir_sr_q;
  reg  [3:0]  ir_q;
  reg  [31:0] dr_sr_q;
  // Test reset pin only counts in 5-wire mode; mode-select reset always works
  wire        trst_hit = (dps_q == `DPS_JTAG5) & ~trst_n_s;

  always @* begin
    case (tap_q)
      S_TLR:   tap_d = tms_s ? S_TLR   : S_RTI;
      S_RTI:   tap_d = tms_s ? S_SELDR : S_RTI;
      S_SELDR: tap_d = tms_s ? S_SELIR : S_CAPDR;
      S_CAPDR: tap_d = tms_s ? S_EX1DR : S_SHDR;
      S_SHDR:  tap_d = tms_s ? S_EX1DR : S_SHDR;
      S_EX1DR: tap_d = tms_s ? S_UPDR  : S_PADR;
      S_PADR:  tap_d = tms_s ? S_EX2DR : S_PADR;
      S_EX2DR: tap_d = tms_s ? S_UPDR  : S_SHDR;
      S_UPDR:  tap_d = tms_s ? S_SELDR : S_RTI;
      S_SELIR: tap_d = tms_s ? S_TLR   : S_CAPIR;
      S_CAPIR: tap_d = tms_s ? S_EX1IR : S_SHIR;
      S_SHIR:  tap_d = tms_s ? S_EX1IR : S_SHIR;
      S_EX1IR: tap_d = tms_s ? S_UPIR  : S_PAIR;
      S_PAIR:  tap_d = tms_s ? S_EX2IR : S_PAIR;
      S_EX2IR: tap_d = tms_s ? S_UPIR  : S_SHIR;
      S_UPIR:  tap_d = tms_s ? S_SELDR : S_RTI;
      default: tap_d = S_TLR;
    endcase
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tap_q            <= S_TLR;
      ir_sr_q          <= 4'h0;
      ir_q             <= `INS_IDCODE;
      dr_sr_q          <= 32'h0000_0000;
      bscan_out        <= 8'h00;
      bscan_oe         <= 1'b0;
      device_reset_req <= 1'b0;
    end else begin
      device_reset_req <= 1'b0;
      if (!jtag_on || trst_hit) begin
        tap_q    <= S_TLR;
        ir_q     <= `INS_IDCODE;
        bscan_oe <= 1'b0;
      end else if (tck_rise) begin
        tap_q <= tap_d;
        case (tap_q)
          S_TLR: begin
            ir_q     <= `INS_IDCODE;
            bscan_oe <= 1'b0;
          end
          S_CAPIR: ir_sr_q <= `IR_CAPTURE;
          S_SHIR:  ir_sr_q <= {tdi_s, ir_sr_q[3:1]};
          S_UPIR:  ir_q    <= ir_sr_q;
          S_CAPDR: begin
            case (ir_q)
              `INS_IDCODE: dr_sr_q <= `DEV_IDCODE;
              `INS_SAMPLE, `INS_EXTEST: dr_sr_q <= {24'h00_0000, bscan_in};
              default:     dr_sr_q <= 32'h0000_0000;
            endcase
          end
          S_SHDR: begin
            case (ir_q)
              `INS_IDCODE: dr_sr_q <= {tdi_s, dr_sr_q[31:1]};
              `INS_SAMPLE, `INS_EXTEST: dr_sr_q <= {24'h00_0000, tdi_s, dr_sr_q[7:1]};
              default:     dr_sr_q <= {31'h0000_0000, tdi_s};
            endcase
          end
          S_UPDR: begin
            if (ir_q == `INS_EXTEST) begin
              bscan_out <= dr_sr_q[7:0];
              bscan_oe  <= 1'b1;
            end
            // Ports-disabled setting blocks the register-triggered reset
            if (ir_q == `INS_DEVRESET && dr_sr_q[0] && dps_q != `DPS_DISABLED) begin
              device_reset_req <= 1'b1;
            end
          end
          default: ir_q <= ir_q;
        endcase
      end
    end
  end

  // Data out changes on the falling test clock edge, per the scan convention
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tdo_out <= 1'b0;
      tdo_oe  <= 1'b0;
    end else if (!jtag_on) begin
      tdo_out <= 1'b0;
      tdo_oe  <= 1'b0;
    end else if (tck_fall) begin
      tdo_out <= (tap_q == S_SHIR) ? ir_sr_q[0] : dr_sr_q[0];
      tdo_oe  <= (tap_q == S_SHIR) || (tap_q == S_SHDR);
    end
  end

  // --------------------------------------------------------------------------
  // Pin direction and serial-wire data drive
  // --------------------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tms_out          <= 1'b0;
      tms_oe           <= 1'b0;
      usb_dm_out       <= 1'b0;
      usb_dm_oe        <= 1'b0;
      jtag_pins_gpio   <= 1'b1;
      swd_on_jtag_pins <= 1'b0;
      swd_on_usb_pins  <= 1'b0;
    end else begin
      // Mode-select pin only turns around while serial-wire owns it
      tms_out          <= swd_dout;
      tms_oe           <= swd_q[0] & ~jtag_on & ~dps_jtag & swd_drive;
      usb_dm_out       <= swd_dout;
      usb_dm_oe        <= swd_q[1] & swd_drive;
      jtag_pins_gpio   <= ~jtag_on & ~swd_q[0];
      swd_on_jtag_pins <= swd_q[0];
      swd_on_usb_pins  <= swd_q[1];
    end
  end

  // --------------------------------------------------------------------------
  // Firmware control of debug and trace units
  // --------------------------------------------------------------------------
  reg  [31:0] ctrl_q;
  wire        wr_ctrl = reg_wr && (reg_addr == `REG_CTRL);

  always @* begin
    ctrl_to_jtag = wr_ctrl && reg_wdata[`CTRL_TO_JTAG_BIT] && port_ok;
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= {29'h0000_0000, reg_wdata[`CTRL_TRACE_HI:`CTRL_TRACE_LO],
                 reg_wdata[`CTRL_DBG_EN_BIT]};
    end
  end

  wire [1:0] trace_sel = ctrl_q[`CTRL_TRACE_HI:`CTRL_TRACE_LO];

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      debug_enable               <= 1'b0;
      single_pin_trace_output_en <= 1'b0;
      parallel_trace_port_en     <= 1'b0;
    end else begin
      debug_enable               <= ctrl_q[`CTRL_DBG_EN_BIT] & port_ok;
      single_pin_trace_output_en <= ctrl_q[`CTRL_DBG_EN_BIT] & port_ok &
                                    (trace_sel == `TRACE_SINGLE);
      parallel_trace_port_en     <= ctrl_q[`CTRL_DBG_EN_BIT] & port_ok &
                                    (trace_sel == `TRACE_PARALLEL);
    end
  end

  // --------------------------------------------------------------------------
  // Register read port
  // --------------------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `REG_CTRL:   reg_rdata <= ctrl_q;
        `REG_STATUS: reg_rdata <= {18'h0_0000, ir_q, tap_q, swd_q, locked_q, jtag_on,
                                   dps_q};
        `REG_IDCODE: reg_rdata <= `DEV_IDCODE;
        default:     reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule // jtag_debug_port_access

`default_nettype wire

// ---- tb/jtag_dbg_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "jtag_dbg_regs.vh"
// ----------------------------
// Port checks of the debug port
// ----------------------------
module jtag_dbg_checker (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       reg_wr,
  input wire logic       swd_drive,
  input wire logic [1:0] debug_port_select_setting,
  input wire logic       security_lock,
  input wire logic       tdo_oe,
  input wire logic       tms_oe,
  input wire logic       usb_dm_oe,
  input wire logic       bscan_oe,
  input wire logic       device_reset_req,
  input wire logic       jtag_pins_gpio,
  input wire logic       swd_on_jtag_pins,
  input wire logic       swd_on_usb_pins,
  input wire logic       debug_enable,
  input wire logic       single_pin_trace_output_en,
  input wire logic       parallel_trace_port_en
);
  int unsigned since_q;
  logic [1:0]  dps_q;
  logic        lock_q;
  logic        settled;

  // Straps are taken once at the first edge; outputs follow a few edges later
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      since_q <= 0;
      dps_q   <= 2'h0;
      lock_q  <= 1'b0;
    end else begin
      if (since_q < 2000) since_q <= since_q + 1;
      if (since_q == 0) begin
        dps_q  <= debug_port_select_setting;
        lock_q <= security_lock;
      end
    end
  end
  assign settled = (since_q >= 4);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_one_pair: assert property (!(swd_on_jtag_pins && swd_on_usb_pins))
    else $error("both serial-wire pairs active");
  a_key_window: assert property ($rose(swd_on_jtag_pins) || $rose(swd_on_usb_pins)
    |-> since_q <= 1012) else $error("serial-wire acquired after key window");
  a_trace_single: assert property (
    !(single_pin_trace_output_en && parallel_trace_port_en)) else $error("two trace outputs");
  a_fw_enable: assert property ($rose(debug_enable)
    || $rose(single_pin_trace_output_en) || $rose(parallel_trace_port_en)
    |-> $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3))
    else $error("debug or trace enabled without a write");
  a_rst_pulse: assert property (device_reset_req |=> !device_reset_req)
    else $error("device reset request longer than one cycle");
  a_rst_refused: assert property (
    settled && dps_q == `DPS_DISABLED |-> !device_reset_req)
    else $error("device reset with ports disabled");
  a_lock_quiet: assert property (settled && lock_q |-> !swd_on_jtag_pins
    && !swd_on_usb_pins && !tdo_oe && !device_reset_req) else $error("port active when locked");
  a_gpio_quiet: assert property (jtag_pins_gpio |-> !tdo_oe && !bscan_oe)
    else $error("test pins driven while released to general use");
  a_tms_input: assert property (settled && (dps_q == `DPS_JTAG4 || dps_q == `DPS_JTAG5)
    |-> !tms_oe) else $error("mode-select driven in test port setting");
  a_tms_cause: assert property (tms_oe |-> $past(swd_drive)
    && (swd_on_jtag_pins || $past(swd_on_jtag_pins))) else $error("mode-select driven unasked");
  a_usb_cause: assert property (usb_dm_oe |-> $past(swd_drive)
    && (swd_on_usb_pins || $past(swd_on_usb_pins))) else $error("usb data pin driven unasked");

  c_usb_pair: cover property ($rose(swd_on_usb_pins));
  c_jtag_pair: cover property ($rose(swd_on_jtag_pins));
  c_dev_reset: cover property (device_reset_req);
  c_extest: cover property (bscan_oe && !jtag_pins_gpio);
endmodule // jtag_dbg_checker

bind jtag_debug_port_access jtag_dbg_checker u_chk (
  .clk_sys, .rst_n, .reg_wr, .swd_drive, .debug_port_select_setting, .security_lock,
  .tdo_oe, .tms_oe, .usb_dm_oe, .bscan_oe, .device_reset_req, .jtag_pins_gpio,
  .swd_on_jtag_pins, .swd_on_usb_pins, .debug_enable, .single_pin_trace_output_en,
  .parallel_trace_port_en
);
`default_nettype wire

// ---- tb/jtag_host_probe.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------
// Host probe on the test pins
// ----------------------------
module jtag_host_probe (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trst_n,
  output logic      usb_clk,
  output logic      usb_dat,
  input  wire logic tdo
);
  localparam int HALF_NS = 40;

  // Clocks stand low between frames
  initial begin
    tck     = 1'b0;
    tms     = 1'b1;
    tdi     = 1'b0;
    trst_n  = 1'b1;
    usb_clk = 1'b0;
    usb_dat = 1'b0;
  end

  // One test clock; 80 ns keeps well under a third of the system clock
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #HALF_NS;
    q   = tdo;
    tck = 1'b1;
    #HALF_NS;
    tck = 1'b0;
  endtask

  // Controller reset by mode-select alone, the reset pin may be off
  task automatic tap_reset();
    logic q;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask

  // From idle: shift n bits LSB first through IR or DR, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic q;
    dout = 32'h0000_0000;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    tdi = ~tdi;
  endtask

  // In 5-wire mode test reset leaves the controller in reset state; one low step returns it to idle
  task automatic pulse_trst();
    logic q;
    trst_n = 1'b0;
    #200;
    trst_n = 1'b1;
    #200;
    step(1'b0, 1'b0, q);
  endtask

  // Key MSB first on clock rises of the chosen pair, sent at whatever time the caller picks
  task automatic send_key(input logic usb, input logic [15:0] k);
    for (int i = 15; i >= 0; i--) begin
      if (usb) usb_dat = k[i];
      else tms = k[i];
      #HALF_NS;
      if (usb) usb_clk = 1'b1;
      else tck = 1'b1;
      #HALF_NS;
      usb_clk = 1'b0;
      tck     = 1'b0;
    end
    usb_dat = ~usb_dat;
  endtask
endmodule // jtag_host_probe
`default_nettype wire

// ---- tb/tb_jtag_debug_port_access.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "jtag_dbg_regs.vh"
module tb_jtag_debug_port_access;
  logic        clk_sys, rst_n, reg_wr, reg_rd, swd_drive, swd_dout, security_lock;
  logic [7:0]  reg_addr, bscan_in;
  logic [31:0] reg_wdata;
  logic [1:0]  debug_port_select_setting;
  wire  [31:0] reg_rdata;
  wire  [7:0]  bscan_out;
  wire         tck_in, tms_in, tdi_in, trst_n_in, usb_dp_in, usb_dm_in, tms_drv, usb_dat_drv;
  wire         tdo_out, tdo_oe, tms_out, tms_oe, usb_dm_out, usb_dm_oe, bscan_oe, tdo_line;
  wire         device_reset_req, jtag_pins_gpio, swd_on_jtag_pins, swd_on_usb_pins;
  wire         debug_enable, single_pin_trace_output_en, parallel_trace_port_en;
  int          fails, tests_run, resets;

  // Shared pins resolve by enable; the test data line has a pull-up
  assign tms_in    = tms_oe ? tms_out : tms_drv;
  assign usb_dm_in = usb_dm_oe ? usb_dm_out : usb_dat_drv;
  assign tdo_line  = tdo_oe ? tdo_out : 1'b1;

  jtag_host_probe host (.tck(tck_in), .tms(tms_drv), .tdi(tdi_in), .trst_n(trst_n_in),
    .usb_clk(usb_dp_in), .usb_dat(usb_dat_drv), .tdo(tdo_line));
  jtag_debug_port_access uut (
    .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .tck_in, .tms_in, .tdi_in, .trst_n_in, .usb_dp_in, .usb_dm_in,
    .tdo_out, .tdo_oe, .tms_out, .tms_oe, .usb_dm_out, .usb_dm_oe,
    .swd_drive, .swd_dout, .debug_port_select_setting, .security_lock,
    .bscan_in, .bscan_out, .bscan_oe, .device_reset_req, .jtag_pins_gpio,
    .swd_on_jtag_pins, .swd_on_usb_pins, .debug_enable,
    .single_pin_trace_output_en, .parallel_trace_port_en);

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (device_reset_req === 1'b1) resets++;

  // ----------------------------
  // Shared tasks
  // ----------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic boot(input logic [1:0] sel, input logic lock);
    rst_n                     <= 1'b0;
    debug_port_select_setting <= sel;
    security_lock             <= lock;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic wrap_up();
    $display("mismatches %0d, comparisons %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #200_000;
    fails++;
    wrap_up();
  end

  // ----------------------------
  // Scenarios
  // ----------------------------
  initial begin : main
    logic [31:0] v;
    logic [1:0]  modes [3];
    int          n0;
    modes = '{`DPS_JTAG4, `DPS_JTAG5, `DPS_DISABLED};
    {rst_n, reg_wr, reg_rd, security_lock} = 4'h0;
    {swd_drive, swd_dout} = 2'h3;
    {reg_addr, bscan_in, reg_wdata} = 48'h0000_0000_0000;
    debug_port_select_setting = `DPS_JTAG4;
    boot(`DPS_JTAG4, 1'b0);
    check(jtag_pins_gpio, 0);
    check({debug_enable, single_pin_trace_output_en, parallel_trace_port_en}, 0);
    rd(`REG_STATUS, v);
    check(v[3:0], 4'h4);
    rd(`REG_IDCODE, v);
    check(v, `DEV_IDCODE);
    wr(8'h0C, 32'hFFFF_FFFF);
    rd(8'h0C, v);
    check(v, 0);
    for (int t = 0; t < 3; t++) begin
      wr(`REG_CTRL, 32'(t * 2 + 1));
      repeat (3) @(posedge clk_sys);
      check(debug_enable, 1);
      check({single_pin_trace_output_en, parallel_trace_port_en}, {t == 1, t == 2});
    end
    host.tap_reset();
    host.scan(1'b0, 32, 32'h0000_0000, v);
    check(v, `DEV_IDCODE);
    host.scan(1'b1, 4, 32'(`INS_SAMPLE), v);
    check(v[3:0], `IR_CAPTURE);
    @(posedge clk_sys) bscan_in <= 8'hA5;
    host.scan(1'b0, 8, 32'h0000_0000, v);
    check(v[7:0], 8'hA5);
    host.scan(1'b1, 4, 32'(`INS_EXTEST), v);
    host.scan(1'b0, 8, 32'h0000_003C, v);
    repeat (4) @(posedge clk_sys);
    check({bscan_oe, bscan_out}, 9'h13C);
    foreach (modes[i]) begin
      boot(modes[i], 1'b0);
      check(jtag_pins_gpio, modes[i] == `DPS_DISABLED);
      n0 = resets;
      host.tap_reset();
      host.scan(1'b1, 4, 32'(`INS_DEVRESET), v);
      host.scan(1'b0, 1, 32'h0000_0001, v);
      repeat (6) @(posedge clk_sys);
      check(resets - n0, modes[i] != `DPS_DISABLED);
      host.scan(1'b1, 4, 32'(`INS_BYPASS), v);
      host.pulse_trst();
      host.scan(1'b0, 32, 32'h0000_0000, v);
      check(v, (i == 0) ? 32'h0000_0000 : (i == 1) ? `DEV_IDCODE : 32'hFFFF_FFFF);
    end
    for (int p = 0; p < 2; p++) begin
      boot(`DPS_SWD, 1'b0);
      host.send_key(p[0], `SWD_KEY);
      host.send_key(!p[0], `SWD_KEY);
      repeat (8) @(posedge clk_sys);
      check({swd_on_usb_pins, swd_on_jtag_pins}, p ? 2'b10 : 2'b01);
      check({usb_dm_oe, tms_oe, p ? usb_dm_out : tms_out}, p ? 3'b101 : 3'b011);
      {swd_drive, swd_dout} <= 2'h0;
      repeat (3) @(posedge clk_sys);
      check({usb_dm_oe, tms_oe, usb_dm_out, tms_out}, 0);
      {swd_drive, swd_dout} <= 2'h3;
      wr(`REG_CTRL, 32'h0000_0008);
      repeat (4) @(posedge clk_sys);
      check({swd_on_usb_pins, swd_on_jtag_pins, tms_oe, usb_dm_oe}, 0);
    end
    boot(`DPS_SWD, 1'b0);
    repeat (1100) @(posedge clk_sys);
    host.send_key(1'b1, `SWD_KEY);
    repeat (8) @(posedge clk_sys);
    check(swd_on_usb_pins, 0);
    boot(`DPS_JTAG4, 1'b0);
    host.send_key(1'b0, `SWD_KEY);
    repeat (8) @(posedge clk_sys);
    check(tms_oe, 0);
    boot(`DPS_JTAG4, 1'b1);
    rd(`REG_STATUS, v);
    check(v[3], 1);
    host.send_key(1'b1, `SWD_KEY);
    host.tap_reset();
    host.scan(1'b0, 32, 32'h0000_0000, v);
    check(v, 32'hFFFF_FFFF);
    check(swd_on_usb_pins, 0);
    wrap_up();
  end
endmodule // tb_jtag_debug_port_access
`default_nettype wire
